// ---- include/sop_consts.vh ----
// Constants for the safety output supervisor
`ifndef SOP_CONSTS_VH
`define SOP_CONSTS_VH

// Register byte offsets
`define SOP_CTRL_OFS      6'h00
`define SOP_STATUS_OFS    6'h04
`define SOP_IRQ_STAT_OFS  6'h08
`define SOP_IRQ_MASK_OFS  6'h0C
`define SOP_MUTE_GAP_OFS  6'h10
`define SOP_MUTE_MAX_OFS  6'h14
`define SOP_OVR_MAX_OFS   6'h18
`define SOP_AREA_MAP_OFS  6'h1C
`define SOP_AREA_NEXT_OFS 6'h20

// Control fields
`define SOP_CTRL_AUTO     0
`define SOP_CTRL_ILOCK    1
`define SOP_CTRL_MUTE_EN  2
`define SOP_CTRL_ORDER    3
`define SOP_CTRL_REF_EN   4
`define SOP_CTRL_SEQ_EN   5
`define SOP_CTRL_W        6

// Status fields
`define SOP_ST_OUT        0
`define SOP_ST_MUTED      1
`define SOP_ST_OVR        2
`define SOP_ST_LOCK       3
`define SOP_ST_SEQF       4
`define SOP_ST_AREA_LO    5

// Event bits
`define SOP_EV_INTRUSION  0
`define SOP_EV_MUTE_FAULT 1
`define SOP_EV_MUTE_TMO   2
`define SOP_EV_OVR_TMO    3
`define SOP_EV_REF        4
`define SOP_EV_AREA_SEQ   5
`define SOP_EV_CONTAM     6
`define SOP_EV_W          7

// Reset values
`define SOP_CTRL_RST      6'h02
`define SOP_MASK_RST      7'h00
`define SOP_MUTE_GAP_RST  32'h000F4240
`define SOP_MUTE_MAX_RST  32'h05F5E100
`define SOP_OVR_MAX_RST   32'h05F5E100
`define SOP_AREA_MAP_RST  8'hE4
`define SOP_AREA_NEXT_RST 8'h39

`endif

// ---- hdl/sop_sync.v ----
// Two-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps
module sop_sync #(
   parameter W = 1
) (
   input  wire         clk,
   input  wire         rst,
   input  wire [W-1:0] d,
   output wire [W-1:0] q
);
   reg [W-1:0] meta_r;
   reg [W-1:0] sync_r;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_r <= {W{1'b0}};
         sync_r <= {W{1'b0}};
      end else begin
         meta_r <= d;
         sync_r <= meta_r;
      end
   end

   assign q = sync_r;
endmodule // sop_sync

// ---- hdl/sop_supervisor.v ----
// Safety switching output supervisor with Avalon-MM registers
// Contract
// [R1] Output off on object in protection zone
// [R2] Output stays off while object in zone
// [R3] Auto restart: output on once zone clear
// [R4] Manual restart: output held off after intrusion
// [R5] Start interlock holds output off until reset
// [R6] Object outside muting area ends muting
// [R7] Wrong muting input order blocks muting
// [R8] Muting input gap over interval blocks muting
// [R9] Override ends after maximum override period
// [R10] Muting ends after maximum muting period
// [R11] Reference displacement switches output off
// [R12] Area order violation switches output off
// [R13] Window contamination switches output off
// [R14] Area from mapping of select inputs, shown
// [R15] Muted: inside-muting-area detections keep output
`timescale 1ns/1ps
`include "sop_consts.vh"
module sop_supervisor (
   input  wire        clk,
   input  wire        rst,
   input  wire [5:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   input  wire [3:0]  avs_byteenable,
   output wire [31:0] avs_readdata,
   output wire        avs_waitrequest,
   input  wire        zone_obj,
   input  wire        zone_obj_outside_mute,
   input  wire        ref_displaced,
   input  wire        window_contam,
   input  wire        reset_in,
   input  wire        mute_in1,
   input  wire        mute_in2,
   input  wire        override_in,
   input  wire [1:0]  area_sel,
   output wire        safety_switch_output,
   output wire        muting_active,
   output wire [1:0]  area_index,
   output wire        irq
);
   localparam [1:0] MS_IDLE  = 2'h0;
   localparam [1:0] MS_FIRST = 2'h1;
   localparam [1:0] MS_MUTED = 2'h2;
   localparam [1:0] MS_BLOCK = 2'h3;

   function [1:0] pick2;
      input [7:0] tbl;
      input [1:0] idx;
      begin
         pick2 = tbl[idx*2 +: 2];
      end
   endfunction

   function [31:0] bmerge;
      input [31:0] old;
      input [31:0] wd;
      input [3:0]  be;
      integer i;
      begin
         bmerge = old;
         for (i = 0; i < 4; i = i + 1) begin
            if (be[i])
               bmerge[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
   endfunction

   wire [5:0] pin_q;
   sop_sync #(.W(6)) u_sync (
      .clk (clk),
      .rst (rst),
      .d   ({area_sel, override_in, mute_in2, mute_in1, reset_in}),
      .q   (pin_q)
   );
   wire       rst_s  = pin_q[0];
   wire       m1_s   = pin_q[1];
   wire       m2_s   = pin_q[2];
   wire       ovr_s  = pin_q[3];
   wire [1:0] asel_s = pin_q[5:4];

   reg [`SOP_CTRL_W-1:0] ctrl_r;
   reg [`SOP_EV_W-1:0]   irq_stat_r;
   reg [`SOP_EV_W-1:0]   irq_mask_r;
   reg [31:0]            mute_gap_r;
   reg [31:0]            mute_max_r;
   reg [31:0]            ovr_max_r;
   reg [7:0]             area_map_r;
   reg [7:0]             area_next_r;
   reg                   wait_r;
   reg [31:0]            rdata_r;
   reg                   out_r;
   reg                   muted_r;
   reg                   ovr_r;
   reg                   lock_r;
   reg                   boot_r;
   reg                   seqf_r;
   reg [1:0]             area_r;
   reg                   irq_r;
   reg [1:0]             ms_r;
   reg [31:0]            mcnt_r;
   reg [31:0]            ocnt_r;
   reg                   rst_d_r;
   reg                   ovr_d_r;
   reg                   contam_d_r;
   reg                   ref_d_r;

   // Bus access phase
   wire req    = avs_read | avs_write;
   wire access = req & ~wait_r;
   wire wr     = access & avs_write;

   wire auto_m  = ctrl_r[`SOP_CTRL_AUTO];
   wire ilock   = ctrl_r[`SOP_CTRL_ILOCK];
   wire mute_en = ctrl_r[`SOP_CTRL_MUTE_EN];
   wire order   = ctrl_r[`SOP_CTRL_ORDER];
   wire ref_en  = ctrl_r[`SOP_CTRL_REF_EN];
   wire seq_en  = ctrl_r[`SOP_CTRL_SEQ_EN];

   wire first_in  = order ? m2_s : m1_s;
   wire second_in = order ? m1_s : m2_s;
   wire rst_rise  = rst_s & ~rst_d_r;
   wire ovr_rise  = ovr_s & ~ovr_d_r;

   // Area selection and sequence check
   wire [1:0] area_new = pick2(area_map_r, asel_s);                // [R14]
   wire       area_chg = area_new != area_r;
   wire       seq_bad  = seq_en & area_chg &
                         (area_new != pick2(area_next_r, area_r)); // [R12]

   // Muting sequencer next state
   reg [1:0]  ms_nxt;
   reg        mfault_ev;
   reg        mtmo_ev;
   always @* begin
      ms_nxt    = ms_r;
      mfault_ev = 1'b0;
      mtmo_ev   = 1'b0;
      case (ms_r)
         MS_IDLE: begin
            if (!mute_en)
               ms_nxt = MS_IDLE;
            else if (first_in & second_in)
               ms_nxt = MS_MUTED;
            else if (first_in)
               ms_nxt = MS_FIRST;
            else if (second_in) begin
               ms_nxt    = MS_BLOCK;                                 // [R7]
               mfault_ev = 1'b1;
            end
         end
         MS_FIRST: begin
            if (!mute_en || !first_in)
               ms_nxt = MS_IDLE;
            else if (mcnt_r > mute_gap_r) begin
               ms_nxt    = MS_BLOCK;                                 // [R8]
               mfault_ev = 1'b1;
            end else if (second_in)
               ms_nxt = MS_MUTED;
         end
         MS_MUTED: begin
            if (!mute_en || !first_in || !second_in)
               ms_nxt = MS_BLOCK;
            else if (zone_obj_outside_mute)
               ms_nxt = MS_BLOCK;                                    // [R6]
            else if (mcnt_r > mute_max_r) begin
               ms_nxt  = MS_BLOCK;                                   // [R10]
               mtmo_ev = 1'b1;
            end
         end
         MS_BLOCK: begin
            if (!m1_s && !m2_s)
               ms_nxt = MS_IDLE;
         end
         default: ms_nxt = MS_IDLE;
      endcase
   end

   wire muted_nxt = ms_nxt == MS_MUTED;
   wire mute_eff  = muted_r | ovr_r;

   // Override: started by rising edge, limited in time
   wire ovr_tmo  = ovr_r & (ocnt_r > ovr_max_r);                   // [R9]
   wire ovr_nxt  = mute_en & ~ovr_tmo &
                   (ovr_r ? ovr_s : ovr_rise);

   // Trip conditions
   wire obj_eff  = mute_eff ? zone_obj_outside_mute : zone_obj;    // [R15]
   wire ref_trip = ref_en & ref_displaced;                          // [R11]
   wire trip     = obj_eff | ref_trip | window_contam | seq_bad;   // [R13]
   wire seqf_nxt = seq_bad | (seqf_r & ~rst_rise);
   wire lock_nxt = boot_r ? ilock :                                 // [R5]
                   (~auto_m & trip) ? 1'b1 :                        // [R4]
                   (rst_rise & ~trip) ? 1'b0 : lock_r;
   wire out_nxt  = ~trip & ~lock_nxt & ~seqf_nxt;                   // [R1]

   wire [`SOP_EV_W-1:0] ev;
   assign ev[`SOP_EV_INTRUSION]  = out_r & ~out_nxt;
   assign ev[`SOP_EV_MUTE_FAULT] = mfault_ev;
   assign ev[`SOP_EV_MUTE_TMO]   = mtmo_ev;
   assign ev[`SOP_EV_OVR_TMO]    = ovr_tmo;
   assign ev[`SOP_EV_REF]        = ref_trip & ~ref_d_r;
   assign ev[`SOP_EV_AREA_SEQ]   = seq_bad;
   assign ev[`SOP_EV_CONTAM]     = window_contam & ~contam_d_r;

   wire [31:0] clr_w = bmerge(32'h00000000, avs_writedata, avs_byteenable);
   wire [`SOP_EV_W-1:0] clr =
      (wr && avs_address == `SOP_IRQ_STAT_OFS) ?
      clr_w[`SOP_EV_W-1:0] : {`SOP_EV_W{1'b0}};
   wire [`SOP_EV_W-1:0] stat_nxt = ev | (irq_stat_r & ~clr);

   // Read mux
   reg [31:0] rd_nxt;
   always @* begin
      rd_nxt = 32'h00000000;
      case (avs_address)
         `SOP_CTRL_OFS:      rd_nxt[`SOP_CTRL_W-1:0] = ctrl_r;
         `SOP_STATUS_OFS: begin
            rd_nxt[`SOP_ST_OUT]   = out_r;
            rd_nxt[`SOP_ST_MUTED] = muted_r;
            rd_nxt[`SOP_ST_OVR]   = ovr_r;
            rd_nxt[`SOP_ST_LOCK]  = lock_r;
            rd_nxt[`SOP_ST_SEQF]  = seqf_r;
            rd_nxt[`SOP_ST_AREA_LO +: 2] = area_r;
         end
         `SOP_IRQ_STAT_OFS:  rd_nxt[`SOP_EV_W-1:0] = irq_stat_r;
         `SOP_IRQ_MASK_OFS:  rd_nxt[`SOP_EV_W-1:0] = irq_mask_r;
         `SOP_MUTE_GAP_OFS:  rd_nxt = mute_gap_r;
         `SOP_MUTE_MAX_OFS:  rd_nxt = mute_max_r;
         `SOP_OVR_MAX_OFS:   rd_nxt = ovr_max_r;
         `SOP_AREA_MAP_OFS:  rd_nxt[7:0] = area_map_r;
         `SOP_AREA_NEXT_OFS: rd_nxt[7:0] = area_next_r;
         default:            rd_nxt = 32'h00000000;
      endcase
   end

   // Write data merged into the addressed register by byte lane
   wire [31:0] wmerge = bmerge(rd_nxt, avs_writedata, avs_byteenable);

   // Bus slave and registers
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         wait_r      <= 1'b1;
         rdata_r     <= 32'h00000000;
         ctrl_r      <= `SOP_CTRL_RST;
         irq_mask_r  <= `SOP_MASK_RST;
         mute_gap_r  <= `SOP_MUTE_GAP_RST;
         mute_max_r  <= `SOP_MUTE_MAX_RST;
         ovr_max_r   <= `SOP_OVR_MAX_RST;
         area_map_r  <= `SOP_AREA_MAP_RST;
         area_next_r <= `SOP_AREA_NEXT_RST;
      end else begin
         wait_r <= ~(req & wait_r);
         if (req & wait_r & avs_read)
            rdata_r <= rd_nxt;
         if (wr) begin
            case (avs_address)
               `SOP_CTRL_OFS:      ctrl_r      <= wmerge[`SOP_CTRL_W-1:0];
               `SOP_IRQ_MASK_OFS:  irq_mask_r  <= wmerge[`SOP_EV_W-1:0];
               `SOP_MUTE_GAP_OFS:  mute_gap_r  <= wmerge;
               `SOP_MUTE_MAX_OFS:  mute_max_r  <= wmerge;
               `SOP_OVR_MAX_OFS:   ovr_max_r   <= wmerge;
               `SOP_AREA_MAP_OFS:  area_map_r  <= wmerge[7:0];
               `SOP_AREA_NEXT_OFS: area_next_r <= wmerge[7:0];
               default: ;
            endcase
         end
      end
   end

   // Supervisor state
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         out_r      <= 1'b0;
         muted_r    <= 1'b0;
         ovr_r      <= 1'b0;
         lock_r     <= 1'b1;
         boot_r     <= 1'b1;
         seqf_r     <= 1'b0;
         area_r     <= 2'h0;
         irq_r      <= 1'b0;
         irq_stat_r <= {`SOP_EV_W{1'b0}};
         ms_r       <= MS_IDLE;
         mcnt_r     <= 32'h00000000;
         ocnt_r     <= 32'h00000000;
         rst_d_r    <= 1'b0;
         ovr_d_r    <= 1'b0;
         contam_d_r <= 1'b0;
         ref_d_r    <= 1'b0;
      end else begin
         boot_r     <= 1'b0;
         rst_d_r    <= rst_s;
         ovr_d_r    <= ovr_s;
         contam_d_r <= window_contam;
         ref_d_r    <= ref_trip;
         out_r      <= out_nxt;                                  // [R2] [R3]
         lock_r     <= lock_nxt;
         seqf_r     <= seqf_nxt;
         area_r     <= area_new;                                 // [R14]
         ms_r       <= ms_nxt;
         muted_r    <= muted_nxt;
         ovr_r      <= ovr_nxt;
         irq_stat_r <= stat_nxt;
         irq_r      <= |(stat_nxt & irq_mask_r);
         if (ms_nxt != ms_r)
            mcnt_r <= 32'h00000000;
         else if (mcnt_r != 32'hFFFFFFFF)
            mcnt_r <= mcnt_r + 32'h00000001;
         if (!ovr_r)
            ocnt_r <= 32'h00000000;
         else if (ocnt_r != 32'hFFFFFFFF)
            ocnt_r <= ocnt_r + 32'h00000001;
      end
   end

   assign avs_readdata         = rdata_r;
   assign avs_waitrequest      = wait_r;
   assign safety_switch_output = out_r;
   assign muting_active        = muted_r;
   assign area_index           = area_r;
   assign irq                  = irq_r;
endmodule // sop_supervisor

// ---- bench/sop_checker.sv ----
// Port-level assertions for the safety output supervisor
`timescale 1ns/1ps
module sop_checker (
   input wire logic clk,
   input wire logic rst,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire logic zone_obj,
   input wire logic zone_obj_outside_mute,
   input wire logic window_contam,
   input wire logic safety_switch_output,
   input wire logic muting_active
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_req;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence s_ans;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence
   a_bus_answer: assert property (s_req |=> s_ans)
      else $error("bus answer not after one wait state");
   a_contam_off: assert property (
      window_contam |=> !safety_switch_output)
      else $error("output on with contaminated window");
   a_outside_off: assert property (
      zone_obj_outside_mute |=> !safety_switch_output)
      else $error("output on with object outside muting area");
   a_obj_off: assert property (
      zone_obj && !muting_active |=> !safety_switch_output)
      else $error("output on with object in zone");
   a_obj_hold: assert property (
      !safety_switch_output && zone_obj && !muting_active
      |=> !safety_switch_output)
      else $error("output left off state with object in zone");
   a_mute_break: assert property (
      muting_active && zone_obj_outside_mute |=> !muting_active)
      else $error("muting kept with object outside muting area");
   a_mute_rise: assert property (
      $rose(muting_active) |-> !$past(zone_obj_outside_mute))
      else $error("muting began with object outside muting area");
   a_out_rise: assert property (
      $rose(safety_switch_output)
      |-> !$past(window_contam) && !$past(zone_obj_outside_mute))
      else $error("output turned on while a trip was present");
endmodule // sop_checker

bind sop_supervisor sop_checker sop_checker_inst (.clk, .rst, .avs_read,
   .avs_write, .avs_waitrequest, .zone_obj, .zone_obj_outside_mute,
   .window_contam, .safety_switch_output, .muting_active);

// ---- bench/sop_partner.sv ----
// Machine control model driving restart, muting and area pins
`timescale 1ns/1ps
module sop_partner (
   input  wire logic  clk,
   output logic       reset_in = 1'b0,
   output logic       mute_in1 = 1'b0,
   output logic       mute_in2 = 1'b0,
   output logic       override_in = 1'b0,
   output logic [1:0] area_sel = 2'h0
);
   task pulse_reset();
      @(posedge clk) reset_in <= 1'b1;
      repeat (4) @(posedge clk);
      reset_in <= 1'b0;
   endtask
   // Second muting input follows after gap cycles
   task mute_pair(input logic swap, input int gap);
      @(posedge clk);
      if (swap) mute_in2 <= 1'b1;
      else mute_in1 <= 1'b1;
      repeat (gap) @(posedge clk);
      mute_in1 <= 1'b1;
      mute_in2 <= 1'b1;
   endtask
   task mute_drop();
      @(posedge clk);
      mute_in1 <= 1'b0;
      mute_in2 <= 1'b0;
      repeat (5) @(posedge clk);
   endtask
   task set_ovr(input logic v);
      @(posedge clk) override_in <= v;
   endtask
   task set_area(input logic [1:0] v);
      @(posedge clk) area_sel <= v;
   endtask
endmodule // sop_partner

// ---- bench/sop_supervisor_tb.sv ----
// Self-checking testbench for the safety output supervisor
`timescale 1ns/1ps
`include "sop_consts.vh"
module sop_supervisor_tb;
   logic clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
   logic [5:0] avs_address = 6'h00;
   logic [3:0] avs_byteenable = 4'hF, be_sel = 4'hF;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, d;
   logic avs_waitrequest, zone_obj = 1'b0, zone_obj_outside_mute = 1'b0;
   logic ref_displaced = 1'b0, window_contam = 1'b0, irq;
   logic reset_in, mute_in1, mute_in2, override_in;
   logic safety_switch_output, muting_active;
   logic [1:0] area_sel, area_index;
   int errors = 0, cmp_count = 0;
   always #5 clk = ~clk;
   sop_supervisor sop_supervisor_inst (.clk, .rst, .avs_address, .avs_read,
      .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
      .avs_waitrequest, .zone_obj, .zone_obj_outside_mute, .ref_displaced,
      .window_contam, .reset_in, .mute_in1, .mute_in2, .override_in,
      .area_sel, .safety_switch_output, .muting_active, .area_index, .irq);
   sop_partner sop_partner_inst (.clk, .reset_in, .mute_in1, .mute_in2,
      .override_in, .area_sel);
   task report_and_stop();
      $display("checks %0d errors %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task bus(input logic w, input logic [5:0] a, input logic [31:0] v);
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= v;
      avs_byteenable <= be_sel;
      avs_write <= w;
      avs_read <= !w;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      d = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task t_interlock();
      bus(0, `SOP_CTRL_OFS, 0);
      chk(d, 32'h02);
      bus(0, `SOP_AREA_MAP_OFS, 0);
      chk(d, 32'hE4);
      bus(0, 6'h3C, 0);
      chk(d, 32'h0);
      be_sel = 4'h1;
      bus(1, `SOP_MUTE_GAP_OFS, 32'hFFFFFF05);
      be_sel = 4'hF;
      bus(0, `SOP_MUTE_GAP_OFS, 0);
      chk(d, 32'h000F4205);
      bus(0, `SOP_STATUS_OFS, 0);
      chk(d & 32'h9, 32'h8);
      sop_partner_inst.pulse_reset();
      cyc(5);
      chk({31'h0, safety_switch_output}, 1);
   endtask
   task t_manual();
      @(posedge clk) zone_obj <= 1'b1;
      cyc(3);
      chk({31'h0, safety_switch_output}, 0);
      cyc(8);
      chk({31'h0, safety_switch_output}, 0);
      @(posedge clk) zone_obj <= 1'b0;
      cyc(8);
      chk({31'h0, safety_switch_output}, 0);
      sop_partner_inst.pulse_reset();
      cyc(5);
      chk({31'h0, safety_switch_output}, 1);
   endtask
   task t_auto();
      bus(1, `SOP_CTRL_OFS, 32'h15);
      bus(1, `SOP_IRQ_STAT_OFS, 32'h7F);
      @(posedge clk) zone_obj <= 1'b1;
      cyc(3);
      chk({31'h0, safety_switch_output}, 0);
      @(posedge clk) zone_obj <= 1'b0;
      cyc(3);
      chk({31'h0, safety_switch_output}, 1);
      @(posedge clk) ref_displaced <= 1'b1;
      cyc(3);
      chk({31'h0, safety_switch_output}, 0);
      @(posedge clk) ref_displaced <= 1'b0;
      @(posedge clk) window_contam <= 1'b1;
      cyc(3);
      chk({31'h0, safety_switch_output}, 0);
      chk({31'h0, irq}, 0);
      bus(1, `SOP_IRQ_MASK_OFS, 32'h40);
      cyc(2);
      chk({31'h0, irq}, 1);
      @(posedge clk) window_contam <= 1'b0;
      bus(1, `SOP_IRQ_STAT_OFS, 32'h40);
      cyc(2);
      chk({31'h0, irq}, 0);
      chk({31'h0, safety_switch_output}, 1);
   endtask
   task t_mute();
      bus(1, `SOP_MUTE_GAP_OFS, 32'h5);
      bus(1, `SOP_MUTE_MAX_OFS, 32'h28);
      sop_partner_inst.mute_pair(1, 2);
      cyc(5);
      chk({31'h0, muting_active}, 0);
      sop_partner_inst.mute_drop();
      sop_partner_inst.mute_pair(0, 12);
      cyc(5);
      chk({31'h0, muting_active}, 0);
      sop_partner_inst.mute_drop();
      sop_partner_inst.mute_pair(0, 2);
      cyc(5);
      chk({31'h0, muting_active}, 1);
      @(posedge clk) zone_obj <= 1'b1;
      cyc(3);
      chk({31'h0, safety_switch_output}, 1);
      @(posedge clk) zone_obj_outside_mute <= 1'b1;
      cyc(3);
      chk({30'h0, safety_switch_output, muting_active}, 0);
      @(posedge clk);
      zone_obj <= 1'b0;
      zone_obj_outside_mute <= 1'b0;
      sop_partner_inst.mute_drop();
      sop_partner_inst.mute_pair(0, 2);
      cyc(5);
      chk({31'h0, muting_active}, 1);
      cyc(45);
      chk({31'h0, muting_active}, 0);
      sop_partner_inst.mute_drop();
      bus(1, `SOP_CTRL_OFS, 32'h1D);
      sop_partner_inst.mute_pair(0, 2);
      cyc(5);
      chk({31'h0, muting_active}, 0);
      sop_partner_inst.mute_drop();
      sop_partner_inst.mute_pair(1, 2);
      cyc(5);
      chk({31'h0, muting_active}, 1);
      sop_partner_inst.mute_drop();
      bus(1, `SOP_CTRL_OFS, 32'h15);
   endtask
   task t_override();
      bus(1, `SOP_OVR_MAX_OFS, 32'h14);
      sop_partner_inst.set_ovr(1);
      cyc(4);
      bus(0, `SOP_STATUS_OFS, 0);
      chk(d & 32'h4, 32'h4);
      cyc(30);
      bus(0, `SOP_STATUS_OFS, 0);
      chk(d & 32'h4, 32'h0);
      sop_partner_inst.set_ovr(0);
   endtask
   task t_area();
      bus(1, `SOP_AREA_MAP_OFS, 32'h1B);
      for (int k = 0; k < 4; k++) begin
         sop_partner_inst.set_area(2'(k));
         cyc(5);
         chk({30'h0, area_index}, 32'(3 - k));
         bus(0, `SOP_STATUS_OFS, 0);
         chk((d >> 5) & 32'h3, 32'(3 - k));
      end
      bus(1, `SOP_AREA_MAP_OFS, 32'hE4);
      sop_partner_inst.set_area(0);
      cyc(5);
      bus(1, `SOP_CTRL_OFS, 32'h35);
      sop_partner_inst.set_area(1);
      cyc(5);
      chk({31'h0, safety_switch_output}, 1);
      sop_partner_inst.set_area(3);
      cyc(5);
      chk({31'h0, safety_switch_output}, 0);
   endtask
   initial begin
      cyc(12);
      rst <= 1'b0;
      t_interlock();
      t_manual();
      t_auto();
      t_mute();
      t_override();
      t_area();
      report_and_stop();
   end
   initial begin
      cyc(5000);
      errors++;
      report_and_stop();
   end
endmodule // sop_supervisor_tb
